// >>> rtl/dcap_debug_port.sv
`include "dcap_defs.svh"

module dcap_debug_port #(
    parameter logic [7:0] PORT_ID = 8'h5A,   // Arbitrary value
    parameter logic [3:0] PORT_CLASS = `DCAP_CLASS_NONE,
    parameter logic [6:0] MAKER_CODE = 7'h15, // Arbitrary value
    parameter logic [3:0] MAKER_BANK = 4'h3,  // Arbitrary value
    parameter logic [3:0] REVISION = 4'h1     // Arbitrary value
) (
    input wire logic core_clk,          // System clock
    input wire logic reset,             // Synchronous reset, active high
    input wire logic swClk,             // Serial wire clock from debugger
    input wire logic apReq,             // Access request level, link domain
    input wire logic apWrite,           // 1 write, 0 read
    input wire logic [7:0] apAddr,      // Register byte offset
    input wire logic [31:0] apWdata,    // Write data
    output logic apAck,                 // Access done, held until apReq low
    output logic [31:0] apRdata,        // Read data
    input wire logic protectActive,     // Port lockout currently active
    input wire logic eraseDone,         // One-cycle pulse: flash and RAM erased
    output logic softResetHold,         // Device held in reset while high
    output logic eraseStart,            // One-cycle pulse: start chip erase
    output logic protectClear,          // One-cycle pulse: clear lockout config
    output logic eraseBusy              // Erase in progress
);
    // Two-stage synchronisers for everything from the link side
    logic [42:0] syncA_reg;
    logic [42:0] syncB_reg;
    logic clkPrev_reg;
    always_ff @(posedge core_clk) begin
        syncA_reg <= {swClk, apReq, apWrite, apAddr, apWdata};
        syncB_reg <= syncA_reg;
        clkPrev_reg <= syncB_reg[42];
    end

    logic sClk;
    logic sReq;
    logic sWrite;
    logic [7:0] sAddr;
    logic [31:0] sWdata;
    assign {sClk, sReq, sWrite, sAddr, sWdata} = syncB_reg;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a[7:2] == ofs[7:2]);
    endfunction

    logic [31:0] identWord;
    assign identWord = ({24'h0, PORT_ID} << `DCAP_ID_PORT_LSB)
                     | ({28'h0, PORT_CLASS} << `DCAP_ID_CLASS_LSB)
                     | ({25'h0, MAKER_CODE} << `DCAP_ID_MAKER_LSB)
                     | ({28'h0, MAKER_BANK} << `DCAP_ID_BANK_LSB)
                     | ({28'h0, REVISION} << `DCAP_ID_REV_LSB);

    logic ack_reg, ack_next;
    logic [31:0] rdata_reg, rdata_next;
    logic hold_reg, hold_next;
    logic start_reg, start_next;
    logic clear_reg, clear_next;
    dcap_pkg::dcap_erase_t state_reg, state_next;
    logic take;

    // Access taken on a link clock rising edge; protection does not gate it
    assign take = sReq && !ack_reg && sClk && !clkPrev_reg;

    always_comb begin
        ack_next = ack_reg;
        rdata_next = rdata_reg;
        hold_next = hold_reg;
        start_next = 1'b0;
        clear_next = 1'b0;
        state_next = state_reg;
        if (!sReq) begin
            ack_next = 1'b0;
        end
        case (state_reg)
            dcap_pkg::ERASE_IDLE: begin
            end
            dcap_pkg::ERASE_BUSY: begin
                if (eraseDone) begin
                    state_next = dcap_pkg::ERASE_IDLE;
                    clear_next = 1'b1;
                end
            end
            default: state_next = dcap_pkg::ERASE_IDLE;
        endcase
        if (take) begin
            ack_next = 1'b1;
            rdata_next = 32'h0;
            if (sWrite) begin
                if (hit(sAddr, `DCAP_OFS_RESET)) begin
                    hold_next = sWdata[`DCAP_BIT_FLAG];
                end else if (hit(sAddr, `DCAP_OFS_ERASE)) begin
                    if (sWdata[`DCAP_BIT_FLAG] && state_reg == dcap_pkg::ERASE_IDLE) begin
                        state_next = dcap_pkg::ERASE_BUSY;
                        start_next = 1'b1;
                    end
                end
            end else begin
                if (hit(sAddr, `DCAP_OFS_RESET)) begin
                    rdata_next[`DCAP_BIT_FLAG] = hold_reg;
                end else if (hit(sAddr, `DCAP_OFS_ESTAT)) begin
                    rdata_next[`DCAP_BIT_FLAG] = (state_reg == dcap_pkg::ERASE_BUSY);
                end else if (hit(sAddr, `DCAP_OFS_PSTAT)) begin
                    rdata_next[`DCAP_BIT_FLAG] = !protectActive;
                end else if (hit(sAddr, `DCAP_OFS_IDENT)) begin
                    rdata_next = identWord;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0;
            hold_reg <= `DCAP_RESET_VAL;
            start_reg <= 1'b0;
            clear_reg <= 1'b0;
            state_reg <= dcap_pkg::ERASE_IDLE;
        end else begin
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
            hold_reg <= hold_next;
            start_reg <= start_next;
            clear_reg <= clear_next;
            state_reg <= state_next;
        end
    end

    assign apAck = ack_reg;
    assign apRdata = rdata_reg;
    assign softResetHold = hold_reg;
    assign eraseStart = start_reg;
    assign protectClear = clear_reg;
    assign eraseBusy = (state_reg == dcap_pkg::ERASE_BUSY);

    erase_goes_busy_a: assert property (@(posedge core_clk) disable iff (reset)
        take && sWrite && hit(sAddr, `DCAP_OFS_ERASE) && sWdata[0] && !eraseBusy
        |=> eraseBusy && eraseStart)
        else $error("erase command did not make status busy");
    busy_until_done_a: assert property (@(posedge core_clk) disable iff (reset)
        eraseBusy && !eraseDone |=> eraseBusy)
        else $error("erase status left busy before erase finished");
    clear_on_done_a: assert property (@(posedge core_clk) disable iff (reset)
        eraseBusy && eraseDone |=> protectClear && !eraseBusy)
        else $error("protection not cleared at erase completion");
    reset_hold_write_a: assert property (@(posedge core_clk) disable iff (reset)
        take && sWrite && hit(sAddr, `DCAP_OFS_RESET) |=> softResetHold == $past(sWdata[0]))
        else $error("soft reset hold does not follow write");
    erase_zero_noop_a: assert property (@(posedge core_clk) disable iff (reset)
        take && sWrite && hit(sAddr, `DCAP_OFS_ERASE) && !sWdata[0] && !eraseBusy
        |=> !eraseBusy && !eraseStart)
        else $error("writing zero to erase command had an effect");
    erase_stat_read_a: assert property (@(posedge core_clk) disable iff (reset)
        take && !sWrite && hit(sAddr, `DCAP_OFS_ESTAT) |=> apRdata == {31'h0, $past(eraseBusy)})
        else $error("erase status read wrong");
    lock_stat_read_a: assert property (@(posedge core_clk) disable iff (reset)
        take && !sWrite && hit(sAddr, `DCAP_OFS_PSTAT)
        |=> apRdata == {31'h0, !$past(protectActive)})
        else $error("protection status read wrong");
    ident_read_a: assert property (@(posedge core_clk) disable iff (reset)
        take && !sWrite && hit(sAddr, `DCAP_OFS_IDENT) |=> apRdata == identWord && apAck)
        else $error("identification read wrong");
    locked_access_a: assert property (@(posedge core_clk) disable iff (reset)
        take && protectActive |=> apAck)
        else $error("access refused while protected");

    // Handshake shape seen from the link side
    ack_after_take_a: assert property (@(posedge core_clk) disable iff (reset)
        take |=> apAck)
        else $error("access taken but not acknowledged");

    ack_drop_a: assert property (@(posedge core_clk) disable iff (reset)
        apAck && !sReq |=> !apAck)
        else $error("acknowledge held after request dropped");

    rdata_stable_a: assert property (@(posedge core_clk) disable iff (reset)
        apAck && $past(apAck) |-> $stable(apRdata))
        else $error("read data changed while acknowledged");

    // Erase strobes are single cycle and only come from their causes
    start_pulse_a: assert property (@(posedge core_clk) disable iff (reset)
        eraseStart |=> !eraseStart)
        else $error("erase start longer than one cycle");

    start_only_cmd_a: assert property (@(posedge core_clk) disable iff (reset)
        eraseStart
        |-> $past(take && sWrite && hit(sAddr, `DCAP_OFS_ERASE) && sWdata[0]))
        else $error("erase start without erase command");

    busy_ignores_erase_a: assert property (@(posedge core_clk) disable iff (reset)
        eraseBusy && take && sWrite && hit(sAddr, `DCAP_OFS_ERASE)
        |=> !eraseStart)
        else $error("erase restarted while busy");

    clear_pulse_a: assert property (@(posedge core_clk) disable iff (reset)
        protectClear |=> !protectClear)
        else $error("lockout clear longer than one cycle");

    clear_only_done_a: assert property (@(posedge core_clk) disable iff (reset)
        protectClear |-> $past(eraseBusy && eraseDone))
        else $error("lockout cleared without erase completion");

    // Register readback and side effects
    hold_stable_a: assert property (@(posedge core_clk) disable iff (reset)
        !(take && sWrite && hit(sAddr, `DCAP_OFS_RESET))
        |=> $stable(softResetHold))
        else $error("soft reset hold changed without a write");

    reset_read_a: assert property (@(posedge core_clk) disable iff (reset)
        take && !sWrite && hit(sAddr, `DCAP_OFS_RESET)
        |=> apRdata == {31'h0, $past(softResetHold)})
        else $error("soft reset readback wrong");

    write_rdata_zero_a: assert property (@(posedge core_clk) disable iff (reset)
        take && sWrite |=> apRdata == 32'h0)
        else $error("write returned nonzero read data");

    // Erase command offset is write-only, so it reads as unmapped
    unmapped_read_a: assert property (@(posedge core_clk) disable iff (reset)
        take && !sWrite && !hit(sAddr, `DCAP_OFS_RESET) && !hit(sAddr, `DCAP_OFS_ESTAT)
        && !hit(sAddr, `DCAP_OFS_PSTAT) && !hit(sAddr, `DCAP_OFS_IDENT)
        |=> apRdata == 32'h0)
        else $error("unmapped read returned nonzero data");

    class_field_a: assert property (@(posedge core_clk) disable iff (reset)
        identWord[16:13] == PORT_CLASS)
        else $error("class field misplaced in identification word");
endmodule

// >>> rtl/dcap_defs.svh
`ifndef DCAP_DEFS_SVH
`define DCAP_DEFS_SVH
`define DCAP_OFS_RESET 8'h00
`define DCAP_OFS_ERASE 8'h04
`define DCAP_OFS_ESTAT 8'h08
`define DCAP_OFS_PSTAT 8'h0C
`define DCAP_OFS_IDENT 8'hFC
`define DCAP_BIT_FLAG 0
`define DCAP_RESET_VAL 1'h0
`define DCAP_ID_PORT_LSB 0
`define DCAP_ID_CLASS_LSB 13
`define DCAP_ID_MAKER_LSB 17
`define DCAP_ID_BANK_LSB 24
`define DCAP_ID_REV_LSB 28
`define DCAP_CLASS_NONE 4'h0
`define DCAP_CLASS_MEM 4'h8
`endif

// >>> rtl/dcap_pkg.sv
package dcap_pkg;
    typedef enum logic [1:0] {
        ERASE_IDLE = 2'b01,
        ERASE_BUSY = 2'b10
    } dcap_erase_t;
endpackage

// >>> test/dcap_dbg_model.sv
module dcap_dbg_model (
    input wire logic core_clk, // System clock
    input wire logic apAck, // Access done
    output logic swClk, // Link clock, still between frames
    output logic apReq, // Access request
    output logic apWrite, // Write select
    output logic [7:0] apAddr, // Register offset
    output logic [31:0] apWdata // Write data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic run = 1'b0;
    initial begin
        swClk = 1'b0;
        apReq = 1'b0;
        apWrite = 1'b0;
        apAddr = 8'h00;
        apWdata = 32'h0;
    end
    always #40 swClk = run ? ~swClk : 1'b0;
    // Power-up is taken as idle with no request; the bench opens no access before reset ends
    task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        apReq <= 1'b1;
        apWrite <= w;
        apAddr <= a;
        apWdata <= d;
        run = 1'b1;
        for (n = 0; n < 99 && apAck !== 1'b1; n++) @(posedge core_clk);
        apReq <= 1'b0;
        apWrite <= ~w;
        apAddr <= ~a;
        apWdata <= ~d;
        run = 1'b0;
        for (n = 0; n < 99 && apAck !== 1'b0; n++) @(posedge core_clk);
    endtask
endmodule

// >>> test/tb_debug_control_access_port.sv
module tb_debug_control_access_port;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] IDENT = {4'h1, 4'h3, 7'h15, 4'h8, 5'h00, 8'h5A};
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic protectActive = 1'b1;
    logic eraseDone = 1'b0;
    logic ackSeen = 1'b0;
    logic swClk, apReq, apWrite, apAck, softResetHold, eraseStart, protectClear, eraseBusy;
    logic [7:0] apAddr;
    logic [31:0] apWdata, apRdata, rnd;
    logic [31:0] expQ[$];
    int failures = 0;
    int checks_done = 0;
    int cyc = 0;
    int starts = 0;
    always #5 core_clk = ~core_clk;
    dcap_debug_port #(.PORT_CLASS(4'h8)) dut (.core_clk(core_clk), .reset(reset),
        .swClk(swClk), .apReq(apReq), .apWrite(apWrite), .apAddr(apAddr),
        .apWdata(apWdata), .apAck(apAck), .apRdata(apRdata), .protectActive(protectActive),
        .eraseDone(eraseDone), .softResetHold(softResetHold), .eraseStart(eraseStart),
        .protectClear(protectClear), .eraseBusy(eraseBusy));
    dcap_dbg_model dbg (.core_clk(core_clk), .apAck(apAck), .swClk(swClk), .apReq(apReq),
        .apWrite(apWrite), .apAddr(apAddr), .apWdata(apWdata));
    task automatic check(input logic [31:0] seen, exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, e);
        expQ.push_back(e);
        dbg.access(w, a, d);
    endtask
    task automatic results;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Lockout store and erase start counter, plus the read-data monitor and timeout
    always @(posedge core_clk) begin
        ackSeen <= apAck;
        cyc <= cyc + 1;
        if (eraseStart === 1'b1) starts <= starts + 1;
        if (reset) protectActive <= 1'b1;
        else if (protectClear === 1'b1) protectActive <= 1'b0;
        if (apAck === 1'b1 && ackSeen !== 1'b1) begin
            check(apRdata, expQ.pop_front(), "read data");
        end
        if (cyc == 20000) begin
            failures++;
            results();
        end
    end
    initial begin
        rnd = $urandom(47061);
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        repeat (4) @(posedge core_clk);
        check(softResetHold, 1'b0, "hold at reset");
        acc(0, 8'h00, 0, 0);
        acc(0, 8'h08, 0, 0);
        acc(0, 8'h0C, 0, 0);
        acc(0, 8'hFC, 0, IDENT);
        acc(0, 8'h10, 0, 0);
        $display("test reset values done");
        rnd = $urandom();
        acc(1, 8'h00, rnd | 32'h1, 0);
        check(softResetHold, 1'b1, "hold set");
        acc(0, 8'h00, 0, 32'h1);
        acc(1, 8'h00, rnd & ~32'h1, 0);
        check(softResetHold, 1'b0, "hold released");
        $display("test soft reset done");
        acc(1, 8'h04, 32'hFFFFFFFE, 0);
        check(eraseBusy, 1'b0, "erase on zero");
        acc(1, 8'h04, 32'h1, 0);
        acc(1, 8'h04, 32'h1, 0);
        acc(0, 8'h08, 0, 32'h1);
        check(starts, 1, "erase starts");
        @(posedge core_clk);
        eraseDone <= 1'b1;
        @(posedge core_clk);
        eraseDone <= 1'b0;
        @(posedge core_clk);
        #1 check(eraseBusy, 1'b0, "ready after erase");
        check(protectActive, 1'b0, "lockout cleared");
        acc(0, 8'h0C, 0, 32'h1);
        acc(0, 8'h08, 0, 0);
        $display("test erase done");
        results();
    end
endmodule
